// File: logic/hcb_pkg.sv
// hcb_pkg: register map, field positions, reset values and carrier types
// for the hub configuration register bank.
// assumes an 8-bit microcontroller data bus with 16-bit addresses.
package hcb_pkg;

  // register addresses in the microcontroller data space
  localparam logic [15:0] HCB_ADDR_VENDOR_LO   = 16'h7fa0;
  localparam logic [15:0] HCB_ADDR_VENDOR_HI   = 16'h7fa1;
  localparam logic [15:0] HCB_ADDR_PRODUCT_LO  = 16'h7fa2;
  localparam logic [15:0] HCB_ADDR_PRODUCT_HI  = 16'h7fa3;
  localparam logic [15:0] HCB_ADDR_RELEASE_LO  = 16'h7fa4;
  localparam logic [15:0] HCB_ADDR_RELEASE_HI  = 16'h7fa5;
  localparam logic [15:0] HCB_ADDR_HUB_CTRL1   = 16'h7fa6;
  localparam logic [15:0] HCB_ADDR_HUB_CTRL2   = 16'h7fa7;

  // bank geometry
  localparam int          HCB_NUM_REGS         = 8;
  localparam logic [15:0] HCB_ADDR_BASE        = HCB_ADDR_VENDOR_LO;
  localparam logic [12:0] HCB_BASE_WORD        = 13'h0ff4;

  // reset value for every register
  localparam logic [7:0]  HCB_RESET_VALUE      = 8'h00;
  localparam logic [7:0]  HCB_READ_IDLE        = 8'h00;

  // register indices inside the bank
  localparam int          HCB_IDX_VENDOR_LO    = 0;
  localparam int          HCB_IDX_VENDOR_HI    = 1;
  localparam int          HCB_IDX_PRODUCT_LO   = 2;
  localparam int          HCB_IDX_PRODUCT_HI   = 3;
  localparam int          HCB_IDX_RELEASE_LO   = 4;
  localparam int          HCB_IDX_RELEASE_HI   = 5;
  localparam int          HCB_IDX_HUB_CTRL1    = 6;
  localparam int          HCB_IDX_HUB_CTRL2    = 7;

  // hub control 1 fields
  localparam int          HCB_CTRL1_RUN_N_BIT  = 7;
  localparam int          HCB_CTRL1_BYPASS_BIT = 2;
  localparam int          HCB_CTRL1_SE0_BIT    = 1;

  // hub control 2 fields
  localparam int          HCB_CTRL2_EXTX_BIT   = 2;

  // microcontroller bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } hcb_bus_req_t;

  // controls handed to the hub core
  typedef struct packed {
    logic [15:0] vendor_id;
    logic [15:0] product_id;
    logic [15:0] release_num;
    logic        hub_controller_run_n;
    logic        hub_bypass;
    logic        drive_single_ended_zero;
    logic        port2_external_transceiver_select;
  } hcb_hub_cfg_t;

  // port routing decided from the controls
  typedef struct packed {
    logic hub_in_reset;
    logic hub_accept_packets;
    logic port2_on_hub;
    logic engine_to_port2;
    logic se0_on_root_port;
    logic se0_on_port2;
    logic port2_internal_xcvr_en;
    logic port2_external_xcvr_en;
  } hcb_route_t;

endpackage : hcb_pkg

// File: logic/hcb_route.sv
// hcb_route: registered port routing derived from the hub controls.
// assumes cfg_i comes from flip-flops on the same clock.
`timescale 1ns/1ps
module hcb_route (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // controls in
  input  wire hcb_pkg::hcb_hub_cfg_t cfg_i,
  // routing out
  output hcb_pkg::hcb_route_t        route_o
);
  import hcb_pkg::*;

  hcb_route_t route_d;
  hcb_route_t route_q;

  // decode controls into port routing
  always_comb begin
    route_d                        = '0;
    route_d.hub_in_reset           = ~cfg_i.hub_controller_run_n;
    route_d.hub_accept_packets     = cfg_i.hub_controller_run_n;
    route_d.port2_on_hub           = ~cfg_i.hub_bypass;
    route_d.engine_to_port2        = cfg_i.hub_bypass;
    route_d.se0_on_root_port       = cfg_i.drive_single_ended_zero & ~cfg_i.hub_bypass;
    route_d.se0_on_port2           = cfg_i.drive_single_ended_zero & cfg_i.hub_bypass;
    route_d.port2_internal_xcvr_en = ~cfg_i.port2_external_transceiver_select;
    route_d.port2_external_xcvr_en = cfg_i.port2_external_transceiver_select;
  end

  // register routing, safe state in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_q <= '{hub_in_reset: 1'b1, port2_on_hub: 1'b1,
                   port2_internal_xcvr_en: 1'b1, default: 1'b0};
    end else begin
      route_q <= route_d;
    end
  end

  assign route_o = route_q;

endmodule // hcb_route

// File: logic/hcb_top.sv
// hcb_top: hub configuration register bank on the microcontroller data bus.
// assumes a synchronous single-cycle bus on CLK_I: write taken on the edge
// with WR_I high, read data registered one edge after RD_I.
`timescale 1ns/1ps
module hcb_top (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // microcontroller data bus
  input  wire logic [15:0] ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [7:0]       RDATA_O,
  output logic             SEL_O,
  // identifiers to the hub descriptor logic
  output logic [15:0]      VENDOR_ID_O,
  output logic [15:0]      PRODUCT_ID_O,
  output logic [15:0]      RELEASE_NUM_O,
  // hub core controls
  output logic             HUB_IN_RESET_O,
  output logic             HUB_ACCEPT_PACKETS_O,
  // port routing
  output logic             PORT2_ON_HUB_O,
  output logic             ENGINE_TO_PORT2_O,
  output logic             SE0_ROOT_PORT_O,
  output logic             SE0_PORT2_O,
  output logic             PORT2_INT_XCVR_EN_O,
  output logic             PORT2_EXT_XCVR_EN_O
);
  import hcb_pkg::*;

  hcb_bus_req_t req;
  hcb_hub_cfg_t cfg;
  hcb_route_t   route;

  logic [7:0]   regs_q [HCB_NUM_REGS];
  logic [7:0]   regs_d [HCB_NUM_REGS];
  logic [7:0]   rdata_d;
  logic [7:0]   rdata_q;
  logic         sel_d;
  logic         sel_q;
  logic         hit;
  logic [2:0]   idx;

  // bundle bus inputs
  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

  // address decode onto the eight byte bank
  assign hit = (req.addr[15:3] == HCB_BASE_WORD);
  assign idx = req.addr[2:0];

  // next register values, one byte lane per register
  generate
    for (genvar g = 0; g < HCB_NUM_REGS; g++) begin : g_reg
      always_comb begin
        regs_d[g] = regs_q[g];
        if (req.wr && hit && (idx == 3'(g))) begin
          regs_d[g] = req.wdata;
        end
      end

      always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
          regs_q[g] <= HCB_RESET_VALUE;
        end else begin
          regs_q[g] <= regs_d[g];
        end
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero and do not select
  always_comb begin
    rdata_d = HCB_READ_IDLE;
    sel_d   = 1'b0;
    if (req.rd && hit) begin
      rdata_d = regs_q[idx];
      sel_d   = 1'b1;
    end
  end

  // registered read data
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rdata_q <= HCB_READ_IDLE;
      sel_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      sel_q   <= sel_d;
    end
  end

  // fields of the bank as hub controls
  always_comb begin
    cfg                         = '0;
    cfg.vendor_id               = {regs_q[HCB_IDX_VENDOR_HI],
                                   regs_q[HCB_IDX_VENDOR_LO]};
    cfg.product_id              = {regs_q[HCB_IDX_PRODUCT_HI],
                                   regs_q[HCB_IDX_PRODUCT_LO]};
    cfg.release_num             = {regs_q[HCB_IDX_RELEASE_HI],
                                   regs_q[HCB_IDX_RELEASE_LO]};
    cfg.hub_controller_run_n    = regs_q[HCB_IDX_HUB_CTRL1][HCB_CTRL1_RUN_N_BIT];
    cfg.hub_bypass              = regs_q[HCB_IDX_HUB_CTRL1][HCB_CTRL1_BYPASS_BIT];
    cfg.drive_single_ended_zero = regs_q[HCB_IDX_HUB_CTRL1][HCB_CTRL1_SE0_BIT];
    cfg.port2_external_transceiver_select =
      regs_q[HCB_IDX_HUB_CTRL2][HCB_CTRL2_EXTX_BIT];
  end

  // registered routing of ports and se0
  hcb_route u_route (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .cfg_i   (cfg),
    .route_o (route)
  );

  // identifier outputs, registered a second time to keep ports on flops
  logic [15:0] vendor_q;
  logic [15:0] product_q;
  logic [15:0] release_q;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      vendor_q  <= 16'h0000;
      product_q <= 16'h0000;
      release_q <= 16'h0000;
    end else begin
      vendor_q  <= cfg.vendor_id;
      product_q <= cfg.product_id;
      release_q <= cfg.release_num;
    end
  end

  // drive ports
  assign RDATA_O              = rdata_q;
  assign SEL_O                = sel_q;
  assign VENDOR_ID_O          = vendor_q;
  assign PRODUCT_ID_O         = product_q;
  assign RELEASE_NUM_O        = release_q;
  assign HUB_IN_RESET_O       = route.hub_in_reset;
  assign HUB_ACCEPT_PACKETS_O = route.hub_accept_packets;
  assign PORT2_ON_HUB_O       = route.port2_on_hub;
  assign ENGINE_TO_PORT2_O    = route.engine_to_port2;
  assign SE0_ROOT_PORT_O      = route.se0_on_root_port;
  assign SE0_PORT2_O          = route.se0_on_port2;
  assign PORT2_INT_XCVR_EN_O  = route.port2_internal_xcvr_en;
  assign PORT2_EXT_XCVR_EN_O  = route.port2_external_xcvr_en;

endmodule // hcb_top

// File: testbench/hcb_top_properties.sv
// hcb_top_properties: port checks for the hub configuration bank.
// assumes hcb_top timing: reads answer next edge, controls lag two edges.
`timescale 1ns/1ps
module hcb_top_properties (
  // clock, reset and bus
  input wire logic        CLK_I, SYS_RST_I, WR_I, RD_I, SEL_O,
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0]  WDATA_I, RDATA_O,
  // identifiers and controls
  input wire logic [15:0] VENDOR_ID_O, PRODUCT_ID_O, RELEASE_NUM_O,
  input wire logic        HUB_IN_RESET_O, HUB_ACCEPT_PACKETS_O, PORT2_ON_HUB_O,
  input wire logic        ENGINE_TO_PORT2_O, SE0_ROOT_PORT_O, SE0_PORT2_O,
  input wire logic        PORT2_INT_XCVR_EN_O, PORT2_EXT_XCVR_EN_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // reads answer on the next edge
  a_mapped_read: assert property (RD_I && ADDR_I[15:3] == 13'h0ff4 |=> SEL_O)
    else $error("no select");
  a_unmapped_read: assert property (RD_I && ADDR_I[15:3] != 13'h0ff4 |=>
    RDATA_O == 8'h00 && !SEL_O) else $error("unmapped read");
  // identifier bytes land two edges after the write
  a_vendor_low: assert property (WR_I && ADDR_I == 16'h7fa0 |-> ##2
    VENDOR_ID_O[7:0] == $past(WDATA_I, 2)) else $error("vendor low");
  a_product_high: assert property (WR_I && ADDR_I == 16'h7fa3 |-> ##2
    PRODUCT_ID_O[15:8] == $past(WDATA_I, 2)) else $error("product high");
  a_release_low: assert property (WR_I && ADDR_I == 16'h7fa4 |-> ##2
    RELEASE_NUM_O[7:0] == $past(WDATA_I, 2)) else $error("release low");
  // hub control decoding
  a_run_bit: assert property (WR_I && ADDR_I == 16'h7fa6 |-> ##2
    HUB_IN_RESET_O == !$past(WDATA_I[7], 2) && HUB_ACCEPT_PACKETS_O != HUB_IN_RESET_O)
    else $error("run bit");
  a_bypass_route: assert property (WR_I && ADDR_I == 16'h7fa6 |-> ##2
    ENGINE_TO_PORT2_O == $past(WDATA_I[2], 2) && PORT2_ON_HUB_O != ENGINE_TO_PORT2_O)
    else $error("bypass");
  a_se0_select: assert property (WR_I && ADDR_I == 16'h7fa6 |-> ##2
    SE0_PORT2_O == ($past(WDATA_I[1], 2) && $past(WDATA_I[2], 2)) &&
    SE0_ROOT_PORT_O == ($past(WDATA_I[1], 2) && !$past(WDATA_I[2], 2)))
    else $error("se0 port");
  a_se0_hold: assert property (WR_I && ADDR_I == 16'h7fa6 && WDATA_I[1] ##1
    !(WR_I && ADDR_I == 16'h7fa6) [*3] |-> SE0_ROOT_PORT_O || SE0_PORT2_O)
    else $error("se0 dropped");
  a_ext_xcvr: assert property (WR_I && ADDR_I == 16'h7fa7 |-> ##2
    PORT2_EXT_XCVR_EN_O == $past(WDATA_I[2], 2) && PORT2_INT_XCVR_EN_O != PORT2_EXT_XCVR_EN_O)
    else $error("transceiver");
endmodule // hcb_top_properties
bind hcb_top hcb_top_properties u_props (.*);

// File: testbench/hcb_fw_model.sv
// hcb_fw_model: firmware bring-up of the hub bank, one write per strobe.
// assumes the bank takes a write on each clock edge with wr high.
`timescale 1ns/1ps
module hcb_fw_model
  import hcb_pkg::*;
(
  // clock and start
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [47:0] ids_i,
  // bus request and status
  output hcb_bus_req_t     req_o,
  output logic             busy_o
);
  initial begin
    req_o = '0;
    busy_o = 1'b0;
  end
  // ids first with product before run bit; reserved bits written zero
  always @(posedge go_i) begin
    busy_o = 1'b1;
    for (int k = 0; k < 7; k++) begin
      @(negedge clk_i);
      req_o = {HCB_ADDR_BASE + 16'(k), (k < 6) ? ids_i[8*k +: 8] : 8'h80, 2'b10};
      @(negedge clk_i);
      req_o.wr = 1'b0;
      req_o.wdata = ~req_o.wdata; // released bus does not hold data
    end
    busy_o = 1'b0;
  end
endmodule // hcb_fw_model

// File: testbench/tb_hcb_top.sv
// tb_hcb_top: self-checking bench for the hub configuration bank.
// assumes hcb_top bus timing and the firmware model beside it.
`timescale 1ns/1ps
module tb_hcb_top;
  import hcb_pkg::*;
  logic CLK_I = 1'b0, SYS_RST_I = 1'b1, go = 1'b0, fw_busy, SEL_O;
  logic HUB_IN_RESET_O, HUB_ACCEPT_PACKETS_O, PORT2_ON_HUB_O, ENGINE_TO_PORT2_O;
  logic SE0_ROOT_PORT_O, SE0_PORT2_O, PORT2_INT_XCVR_EN_O, PORT2_EXT_XCVR_EN_O;
  logic [15:0] VENDOR_ID_O, PRODUCT_ID_O, RELEASE_NUM_O, a;
  logic [7:0]  RDATA_O, d, ctl, mdl [8];
  logic [47:0] ids;
  logic [31:0] se0_seq = 32'h82868480;
  hcb_bus_req_t tb_req = '0, fw_req, bus;
  int n_errors = 0, checks = 0, n;
  assign bus = fw_busy ? fw_req : tb_req;
  assign ctl = {HUB_ACCEPT_PACKETS_O, HUB_IN_RESET_O, ENGINE_TO_PORT2_O, PORT2_ON_HUB_O,
                SE0_ROOT_PORT_O, SE0_PORT2_O, PORT2_INT_XCVR_EN_O, PORT2_EXT_XCVR_EN_O};
  always #50 CLK_I = ~CLK_I;
  hcb_top dut (.CLK_I, .SYS_RST_I, .ADDR_I(bus.addr), .WDATA_I(bus.wdata), .WR_I(bus.wr),
    .RD_I(bus.rd), .RDATA_O, .SEL_O, .VENDOR_ID_O, .PRODUCT_ID_O, .RELEASE_NUM_O,
    .HUB_IN_RESET_O, .HUB_ACCEPT_PACKETS_O, .PORT2_ON_HUB_O, .ENGINE_TO_PORT2_O,
    .SE0_ROOT_PORT_O, .SE0_PORT2_O, .PORT2_INT_XCVR_EN_O, .PORT2_EXT_XCVR_EN_O);
  hcb_fw_model fw (.clk_i(CLK_I), .go_i(go), .ids_i(ids), .req_o(fw_req), .busy_o(fw_busy));
  // expected routing from the two control bytes
  function automatic logic [7:0] exp_ctl(input logic [7:0] c1, input logic [7:0] c2);
    return {c1[7], ~c1[7], c1[2], ~c1[2], c1[1] & ~c1[2], c1[1] & c1[2], ~c2[2], c2[2]};
  endfunction
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one write, strobe held for one edge
  task automatic wr(input logic [15:0] ad, input logic [7:0] dt);
    @(negedge CLK_I);
    tb_req = {ad, dt, 2'b10};
    if (ad[15:3] == HCB_BASE_WORD) mdl[ad[2:0]] = dt;
    @(negedge CLK_I);
    tb_req = {ad, ~dt, 2'b00};
  endtask
  task automatic rd(input logic [15:0] ad);
    @(negedge CLK_I);
    tb_req = {ad, 8'h00, 2'b01};
    @(negedge CLK_I);
    tb_req.rd = 1'b0;
    cmp("rdata", ad[15:3] == HCB_BASE_WORD ? mdl[ad[2:0]] : 8'h00, RDATA_O);
    cmp("sel", 16'(ad[15:3] == HCB_BASE_WORD), 16'(SEL_O));
  endtask
  task automatic outs;
    cmp("vendor", {mdl[1], mdl[0]}, VENDOR_ID_O);
    cmp("product", {mdl[3], mdl[2]}, PRODUCT_ID_O);
    cmp("release", {mdl[5], mdl[4]}, RELEASE_NUM_O);
    cmp("controls", 16'(exp_ctl(mdl[6], mdl[7])), 16'(ctl));
  endtask
  initial begin
    void'($urandom(32'h28a726de));
    foreach (mdl[i]) mdl[i] = 8'h00;
    ids = 48'({$urandom, $urandom});
    repeat (12) @(negedge CLK_I);
    SYS_RST_I = 1'b0;
    outs();
    for (int i = 0; i < 8; i++) rd(HCB_ADDR_BASE + 16'(i));
    // firmware bring-up through the partner
    begin : run
      go = 1'b1;
      @(negedge CLK_I);
      for (n = 0; n < 40 && fw_busy; n++) @(negedge CLK_I);
      if (fw_busy) begin
        n_errors++;
        disable run;
      end
      // let the last control write reach the routing flops
      @(negedge CLK_I);
      for (int k = 0; k < 6; k++) mdl[k] = ids[8*k +: 8];
      mdl[6] = 8'h80;
      outs();
      // se0 on each upstream choice, held past a disconnect, then release
      for (int j = 0; j < 4; j++) begin
        wr(HCB_ADDR_HUB_CTRL1, se0_seq[8*(3-j) +: 8]);
        @(negedge CLK_I);
        outs();
        if (se0_seq[8*(3-j)+1]) begin
          repeat (30) @(negedge CLK_I);
          outs();
        end
      end
      // random traffic, unmapped neighbours included
      repeat (60) begin
        a = 16'h7f9e + 16'($urandom_range(11));
        d = 8'($urandom) & (a == HCB_ADDR_HUB_CTRL2 ? 8'h04 : 8'h86);
        if (a < HCB_ADDR_HUB_CTRL1) d = 8'($urandom);
        wr(a, d);
        rd(a);
        outs();
      end
      // second reset in mid-run clears every register
      @(negedge CLK_I);
      SYS_RST_I = 1'b1;
      repeat (2) @(negedge CLK_I);
      SYS_RST_I = 1'b0;
      foreach (mdl[i]) mdl[i] = 8'h00;
      outs();
      for (int i = 0; i < 8; i++) rd(HCB_ADDR_BASE + 16'(i));
    end
    stop_test();
  end
endmodule // tb_hcb_top
